// [rtl/hsc_selfunc.sv]
// hsc_selfunc: latch, count-disable and sampling functions of one channel
// What this block does
// - latch mode: start/function rise captures into latch1
// - latch input rise always captures into latch2
// - latching ignores count enable
// - external latch lands on next 1ms tick
// - edge ignored while the other source high
// - counting follows count enable command
// - disable mode: start command high halts counting
// - disable mode: active function input halts counting
// - re-enable stays halted while disable source active
// - sampling: trigger rise clears and starts accumulation
// - accumulation stops when interval expires
// - status bit 3 set during sampling run
// - final sample count held after run
// - sampling ignores count enable
// - sampling trigger ignored while other source high
// - retrigger restarts count, timer keeps running
// - saturate at max, raise warning 3050
// - interval latched at run start only
// - interval in 10ms steps, 10 to 655350ms
// - selectable function input polarity
`timescale 1ns/1ns
module hsc_selfunc #(
    // control-cycle length in clocks; silicon keeps the 1 ms default,
    // a shorter value only makes long sampling runs quick to exercise
    parameter int TICK_DIV = hsc_pkg::TICK_CYCLES
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        clk_en,
    input  wire hsc_pkg::hsc_func_type       func_sel,
    input  wire logic                        func_in_neg,
    input  wire logic [hsc_pkg::SMP_SET_W-1:0] smp_set,
    input  wire logic                        count_enable_cmd,
    input  wire logic                        selected_function_start_cmd,
    input  wire logic                        func_in,
    input  wire logic                        latch_in,
    input  wire logic                        pulse_inc,
    input  wire logic signed [hsc_pkg::CNT_W-1:0] current_count,
    output logic                             count_gate,
    output logic signed [hsc_pkg::CNT_W-1:0] latch1_val,
    output logic signed [hsc_pkg::CNT_W-1:0] latch2_val,
    output logic signed [hsc_pkg::CNT_W-1:0] sample_val,
    output logic [hsc_pkg::STAT_W-1:0]       counter_status_word,
    output logic [15:0]                      warn_code
);
    import hsc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input conditioning and edge detection
    logic tick;            // 1 ms control strobe
    logic fin_act;         // function input, polarity applied
    logic cmd_q;           // previous start command
    logic fin_q;           // previous active function input
    logic lin_q;           // previous latch input
    logic lat_pend_q;      // latch2 request waiting for tick
    logic signed [CNT_W-1:0] lat2_hold_q; // count seen at latch rise

    assign fin_act = func_in ^ func_in_neg;

    wire cmd_rise = selected_function_start_cmd & ~cmd_q;
    wire fin_rise = fin_act & ~fin_q;
    // a rise counts only if the other source was low beforehand
    wire trig_raw = (cmd_rise & ~fin_q) | (fin_rise & ~cmd_q);
    // both sources rising together still make a single trigger
    wire trig_ok  = trig_raw;
    wire lin_rise = latch_in & ~lin_q;

    wire is_latch = (func_sel == HSC_FN_LATCH);
    wire is_dis   = (func_sel == HSC_FN_DISABLE);
    wire is_smp   = (func_sel == HSC_FN_SAMPLE);

    hsc_tick_gen #(.TICK_DIV(TICK_DIV)) u_tick (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .tick     (tick)
    );

    // edge history registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= 1'b0;
            fin_q <= 1'b0;
            lin_q <= 1'b0;
        end else if (clk_en) begin
            cmd_q <= selected_function_start_cmd;
            fin_q <= fin_act;
            lin_q <= latch_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // count gating: enable command and disable sources are both levels,
    // so re-enable while a source is high stays halted naturally
    wire dis_src = is_dis & (selected_function_start_cmd | fin_act);
    assign count_gate = count_enable_cmd & ~dis_src;

    ////////////////////////////////////////////////////////////////////
    // latch captures; independent of count enable
    // latch1 is taken immediately; latch2 (pure external) waits for the
    // control tick, matching the slower update path of that capture
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch1_val <= CNT_ZERO;
            latch2_val <= CNT_ZERO;
            lat_pend_q <= 1'b0;
            lat2_hold_q <= CNT_ZERO;
        end else if (clk_en) begin
            if (is_latch && trig_ok) begin
                latch1_val <= current_count;
            end
            // keep the count of the edge itself, not of the later tick
            if (lin_rise) begin
                lat2_hold_q <= current_count;
            end
            // a rise on the tick itself is published at once, so no
            // request is left behind to overwrite it one tick later
            if (lin_rise && !tick) begin
                lat_pend_q <= 1'b1;
            end else if (tick) begin
                lat_pend_q <= 1'b0;
            end
            if (tick && lin_rise) begin
                latch2_val <= current_count;
            end else if (tick && lat_pend_q) begin
                latch2_val <= lat2_hold_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sampling run: tick counter in 10 ms units
    hsc_smp_type       smp_q;       // run state
    logic [SMP_SET_W-1:0] units_q;  // units remaining
    logic [UNIT_W-1:0]  sub_q;      // ticks inside current unit
    logic               ovf_q;      // overflow warning latch

    localparam logic [UNIT_W-1:0] SUB_LAST = UNIT_W'(SMP_UNIT_TICKS - 1);
    localparam logic [SMP_SET_W-1:0] SET_MIN = SMP_SET_W'(MIN_SMP_SET);
    // full-width signed step; a one-bit signed literal would extend to -1
    localparam logic signed [CNT_W-1:0] CNT_STEP = 32'sh00000001;

    wire smp_start = is_smp & trig_ok;
    // zero setting is clamped to the shortest interval
    wire [SMP_SET_W-1:0] set_eff = (smp_set < SET_MIN) ? SET_MIN : smp_set;
    wire unit_end  = tick & (sub_q == SUB_LAST);
    wire run_end   = (smp_q == HSC_SMP_RUN) & unit_end & (units_q == SET_MIN);
    wire at_max    = (sample_val == $signed(CNT_MAX));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            smp_q   <= HSC_SMP_IDLE;
            units_q <= '0;
            sub_q   <= '0;
        end else if (clk_en) begin
            unique case (smp_q)
                HSC_SMP_IDLE: begin
                    if (smp_start) begin
                        smp_q   <= HSC_SMP_RUN;
                        units_q <= set_eff;
                        sub_q   <= '0;
                    end
                end
                HSC_SMP_RUN: begin
                    // retrigger leaves the interval timer alone
                    if (run_end && smp_start) begin
                        // trigger on the closing tick opens a fresh run,
                        // so the cleared count is never left stranded
                        units_q <= set_eff;
                        sub_q   <= '0;
                    end else if (run_end) begin
                        smp_q <= HSC_SMP_IDLE;
                    end else if (unit_end) begin
                        sub_q   <= '0;
                        units_q <= units_q - 1'b1;
                    end else if (tick) begin
                        sub_q <= sub_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // sample accumulator; held once the run ends
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_val <= CNT_ZERO;
            ovf_q      <= 1'b0;
        end else if (clk_en) begin
            if (smp_start) begin
                sample_val <= CNT_ZERO;
            end else if (smp_q == HSC_SMP_RUN && pulse_inc) begin
                if (at_max) begin
                    ovf_q <= 1'b1;
                end else begin
                    sample_val <= sample_val + CNT_STEP;
                end
            end
        end
    end

    assign warn_code = ovf_q ? WARN_SMP_OVF : WARN_NONE;

    always_comb begin
        counter_status_word = '0;
        counter_status_word[STAT_SMP_BIT] = (smp_q == HSC_SMP_RUN);
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // the gate may never open while the enable command is off
    property p_gate;
        @(posedge core_clk) disable iff (!rst_b)
        !count_enable_cmd |-> !count_gate;
    endproperty
    a_gate: assert property (p_gate)
        else $error("gate open while off");

    // start command high in disable mode closes the gate at once
    property p_dis;
        @(posedge core_clk) disable iff (!rst_b)
        (is_dis && selected_function_start_cmd) |-> !count_gate;
    endproperty
    a_dis: assert property (p_dis)
        else $error("disable not halting");

    // an active function input in disable mode closes it as well
    property p_fin;
        @(posedge core_clk) disable iff (!rst_b)
        (is_dis && fin_act) |-> !count_gate;
    endproperty
    a_fin: assert property (p_fin)
        else $error("function input not halting");

    // with both disable levels gone, the enable command alone rules
    property p_reopen;
        @(posedge core_clk) disable iff (!rst_b)
        (count_enable_cmd && !selected_function_start_cmd && !fin_act)
            |-> count_gate;
    endproperty
    a_reopen: assert property (p_reopen)
        else $error("gate stuck after release");

    // latch1 takes the count seen at the accepted trigger edge
    property p_lat1;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && is_latch && trig_ok) |=>
            latch1_val == $past(current_count);
    endproperty
    a_lat1: assert property (p_lat1)
        else $error("latch1 missed");

    // the other functions leave latch1 alone
    property p_quiet;
        @(posedge core_clk) disable iff (!rst_b)
        !is_latch |=> $stable(latch1_val);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("latch1 moved outside latch mode");

    // a latch input rise on a tick publishes that count right away
    property p_lat2;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && tick && lin_rise) |=>
            latch2_val == $past(current_count);
    endproperty
    a_lat2: assert property (p_lat2)
        else $error("latch2 missed");

    // sampling start: count cleared and run flag raised together
    sequence s_smp_trig;
        clk_en && smp_start;
    endsequence
    sequence s_smp_open;
        sample_val == CNT_ZERO && counter_status_word[STAT_SMP_BIT];
    endsequence
    property p_smp_clr;
        @(posedge core_clk) disable iff (!rst_b)
        s_smp_trig |=> s_smp_open;
    endproperty
    a_smp_clr: assert property (p_smp_clr)
        else $error("sample no start");

    // the run flag stays up until the closing tick
    property p_run_flag;
        @(posedge core_clk) disable iff (!rst_b)
        (smp_q == HSC_SMP_RUN && !run_end) |=>
            counter_status_word[STAT_SMP_BIT];
    endproperty
    a_run_flag: assert property (p_run_flag)
        else $error("run flag dropped early");

    // outside a run the final count is frozen for read-out
    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (smp_q == HSC_SMP_IDLE && !smp_start) |=> $stable(sample_val);
    endproperty
    a_hold: assert property (p_hold)
        else $error("sample not held");

    // a pulse at the ceiling leaves the count there and warns
    property p_sat;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && smp_q == HSC_SMP_RUN && pulse_inc && at_max
            && !smp_start) |=> warn_code == WARN_SMP_OVF && at_max;
    endproperty
    a_sat: assert property (p_sat)
        else $error("no saturation");

    // a start rise while the function input is held does nothing
    property p_ign;
        @(posedge core_clk) disable iff (!rst_b)
        (fin_q && cmd_rise) |-> !trig_ok;
    endproperty
    a_ign: assert property (p_ign)
        else $error("edge not ignored");

    // the closing tick drops the run flag unless a trigger reopens
    property p_end;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && run_end && !smp_start) |=>
            !counter_status_word[STAT_SMP_BIT];
    endproperty
    a_end: assert property (p_end)
        else $error("run did not end");
endmodule

// [rtl/hsc_pkg.sv]
// hsc_pkg: shared constants and types for the counter selected-function block
package hsc_pkg;
    // counter function selection
    typedef enum logic [1:0] {
        HSC_FN_LATCH   = 2'h0,
        HSC_FN_DISABLE = 2'h1,
        HSC_FN_SAMPLE  = 2'h2,
        HSC_FN_NONE    = 2'h3
    } hsc_func_type;

    // sampling run state, gray along idle -> run
    typedef enum logic [0:0] {
        HSC_SMP_IDLE = 1'h0,
        HSC_SMP_RUN  = 1'h1
    } hsc_smp_type;

    localparam int          CNT_W          = 32;
    localparam int          SMP_SET_W      = 16;
    // core clock and control tick
    localparam int          CLK_HZ         = 25000000;
    localparam int          CTRL_TICK_MS   = 1;
    localparam int          TICK_CYCLES    = CLK_HZ / 1000 * CTRL_TICK_MS;
    localparam int          TICK_W         = 15;
    // sampling setting is in units of this many ticks (10 ms)
    localparam int          SMP_UNIT_MS    = 10;
    localparam int          SMP_UNIT_TICKS = SMP_UNIT_MS / CTRL_TICK_MS;
    localparam int          UNIT_W         = 4;
    localparam int          MIN_SMP_SET    = 1;
    localparam logic [CNT_W-1:0] CNT_MAX   = 32'h7FFFFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 32'h00000000;
    localparam logic [15:0] WARN_SMP_OVF   = 16'h0BEA;   // code 3050
    localparam logic [15:0] WARN_NONE      = 16'h0000;
    localparam int          STAT_SMP_BIT   = 3;
    localparam int          STAT_W         = 16;
endpackage

// [rtl/hsc_tick_gen.sv]
// hsc_tick_gen: 1 ms internal control cycle strobe
`timescale 1ns/1ns
module hsc_tick_gen #(
    parameter int TICK_DIV = hsc_pkg::TICK_CYCLES   // clocks per tick
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    output logic      tick
);
    import hsc_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    logic [TICK_W-1:0] div_q;   // cycle divider
    wire               wrap = (div_q == TICK_LAST);

    ////////////////////////////////////////////////////////////////////
    // free-running divider, one-cycle strobe at wrap
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (clk_en) begin
            div_q <= wrap ? '0 : div_q + 1'b1;
        end
    end

    assign tick = wrap & clk_en;
endmodule

// [test/hsc_pulse_src.sv]
// hsc_pulse_src: pulse encoder and main counter beside the channel
`timescale 1ns/1ns
module hsc_pulse_src (
    input  wire logic                             core_clk,
    input  wire logic                             rst_b,
    input  wire logic                             pulse_req,
    input  wire logic                             count_gate,
    output logic                                  pulse_inc,
    output logic signed [hsc_pkg::CNT_W-1:0]      current_count
);
    import hsc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // one encoder pulse a cycle after each request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_inc <= 1'b0;
        end else begin
            pulse_inc <= pulse_req;
        end
    end
    // main counter moves only while the channel opens the gate
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            current_count <= CNT_ZERO;
        end else if (pulse_inc && count_gate) begin
            current_count <= current_count + 32'h00000001;
        end
    end
endmodule

// [test/test_hs_counter_selected_functions.sv]
// test_hs_counter_selected_functions: directed bench for the channel
`timescale 1ns/1ns
module test_hs_counter_selected_functions;
    import hsc_pkg::*;
    logic               core_clk = 1'b0;  // 25 MHz
    logic               rst_b    = 1'b0;  // active low
    hsc_func_type       func_sel = HSC_FN_LATCH;
    logic               func_in_neg = 1'b0;
    logic [15:0]        smp_set  = 16'h0001;
    logic               en_cmd   = 1'b0;  // count enable command
    logic               start    = 1'b0;  // function start command
    logic               func_in  = 1'b0;
    logic               latch_in = 1'b0;
    logic               pulse_req = 1'b0;
    logic               pulse_inc;
    logic               count_gate;
    logic signed [31:0] cur, l1, l2, smp;
    logic [15:0]        stat, warn;
    int                 err_total = 0;
    int                 tests_run = 0;
    int                 i;
    longint             t0, el;
    // short control cycle so a full sampling run stays brief
    localparam int      TB_TICK = 2000;
    ////////////////////////////////////////////////////////////////////////
    always #20 core_clk = ~core_clk;
    hsc_pulse_src u_src (.core_clk(core_clk), .rst_b(rst_b),
        .pulse_req(pulse_req), .count_gate(count_gate),
        .pulse_inc(pulse_inc), .current_count(cur));
    hsc_selfunc #(.TICK_DIV(TB_TICK)) dut (.core_clk(core_clk),
        .rst_b(rst_b), .clk_en(1'b1),
        .func_sel(func_sel), .func_in_neg(func_in_neg), .smp_set(smp_set),
        .count_enable_cmd(en_cmd), .selected_function_start_cmd(start),
        .func_in(func_in), .latch_in(latch_in), .pulse_inc(pulse_inc),
        .current_count(cur), .count_gate(count_gate), .latch1_val(l1),
        .latch2_val(l2), .sample_val(smp), .counter_status_word(stat),
        .warn_code(warn));
    ////////////////////////////////////////////////////////////////////////
    // wait whole cycles, landing on a falling edge
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // one compare, mismatch reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    // n encoder pulses, two cycles apart, then let the count settle
    task automatic pulses(input int n);
        repeat (n) begin
            tk(1); pulse_req = 1'b1;
            tk(1); pulse_req = 1'b0;
        end
        tk(2);
    endtask
    task automatic test_done;
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: one latch wait of a tick, one run of ten ticks, margin
    initial begin
        repeat (13 * TB_TICK) @(posedge core_clk);
        err_total++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tk(6); rst_b = 1'b1; tk(1);
        // latch function
        en_cmd = 1'b1; pulses(4); chk(cur, 32'h00000004);
        start = 1'b1; tk(3); chk(l1, 32'h00000004);
        pulses(3); func_in = 1'b1; tk(3); chk(l1, 32'h00000004);
        start = 1'b0; tk(2); func_in = 1'b0; en_cmd = 1'b0;
        pulses(2); chk(cur, 32'h00000007);
        func_in = 1'b1; tk(3); chk(l1, 32'h00000007);
        func_in = 1'b0; latch_in = 1'b1;
        for (i = 0; i < TB_TICK + 10 && l2 !== 32'h00000007; i++) tk(1);
        chk(l2, 32'h00000007);
        latch_in = 1'b0;
        // count-disable function, gate is combinational
        func_sel = HSC_FN_DISABLE; en_cmd = 1'b1;
        tk(1); chk({31'h0, count_gate}, 32'h00000001);
        start = 1'b1; tk(1); chk({31'h0, count_gate}, 32'h0);
        pulses(2); chk(cur, 32'h00000007);
        start = 1'b0; tk(1); chk({31'h0, count_gate}, 32'h1);
        func_in = 1'b1; tk(1); chk({31'h0, count_gate}, 32'h0);
        func_in_neg = 1'b1; tk(1); chk({31'h0, count_gate}, 32'h1);
        func_in = 1'b0; tk(1); chk({31'h0, count_gate}, 32'h0);
        func_in_neg = 1'b0; start = 1'b1; en_cmd = 1'b0; tk(1);
        en_cmd = 1'b1; tk(1); chk({31'h0, count_gate}, 32'h0);
        start = 1'b0; tk(1); chk({31'h0, count_gate}, 32'h1);
        // no function selected: triggers do nothing
        pulses(1); func_sel = HSC_FN_NONE; start = 1'b1; tk(3);
        chk(l1, 32'h00000007);
        chk({31'h0, stat[STAT_SMP_BIT]}, 32'h0);
        start = 1'b0; tk(2);
        // sampling function with the main counter disabled
        func_sel = HSC_FN_SAMPLE; en_cmd = 1'b0; tk(1);
        start = 1'b1; t0 = $time; tk(2); smp_set = 16'hFFFF;
        chk({31'h0, stat[STAT_SMP_BIT]}, 32'h1);
        chk(smp, 32'h00000000);
        pulses(5); chk(smp, 32'h00000005);
        func_in = 1'b1; tk(3); chk(smp, 32'h00000005);
        start = 1'b0; func_in = 1'b0; pulses(3);
        chk(smp, 32'h00000008);
        func_in = 1'b1; tk(3); chk(smp, 32'h00000000);
        chk({31'h0, stat[STAT_SMP_BIT]}, 32'h1);
        func_in = 1'b0; pulses(2);
        for (i = 0; i < 11 * TB_TICK && stat[STAT_SMP_BIT] !== 1'b0; i++)
            tk(1);
        el = ($time - t0) / 40;
        chk({31'h0, el >= (SMP_UNIT_TICKS - 1) * TB_TICK + 2
            && el <= SMP_UNIT_TICKS * TB_TICK + 1}, 32'h1);
        chk({31'h0, stat[STAT_SMP_BIT]}, 32'h0);
        chk(smp, 32'h00000002);
        pulses(2); chk(smp, 32'h00000002);
        chk({16'h0, warn}, {16'h0, WARN_NONE});
        test_done;
    end
endmodule
